// ===== rtl/scl_top.sv
// Purpose: Serial configuration words, reference path and lock detection
// Assumes: Serial pins and sense inputs are asynchronous to ref_clk
// Notes:   Serial clock must be well below a quarter of ref_clk rate
`timescale 1ns/1ps
module scl_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Three-wire serial link
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_load,
   // Reference and phase window sense
   input wire logic reference_input,
   input wire logic win_10ns_ok,
   input wire logic win_6ns_ok,
   // Loop control outputs
   output logic dither_enable,
   output logic cp_low_noise_bias,
   output logic [2:0] mux_source_sel,
   output logic multiplexed_output_pin,
   output logic comparison_clk,
   output logic pd_polarity_pos,
   output logic charge_pump_high_z,
   output logic counters_hold,
   output logic output_buffer_en,
   output logic sleep_active,
   output logic antibacklash_short,
   output logic charge_cancel_en,
   output logic slip_reduction_enable,
   output logic [1:0] divider_mode,
   output logic [11:0] divider_value,
   output logic fast_lock_active,
   output logic resync_pulse,
   // Lock detect
   output logic lock_detect,
   output logic lock_detect_pin
);
   typedef struct packed {
      logic [2:0] clk_sy;
      logic [1:0] dat_sy;
      logic [2:0] ld_sy;
      logic [2:0] ref_sy;
      logic [1:0] w10_sy;
      logic [1:0] w6_sy;
      logic [31:0] shift;
      logic [31:0] w2;
      logic [31:0] w3;
      logic [31:0] w5;
      logic [scl_pkg::RCNT_W-1:0] act_ratio;
      logic act_dbl;
      logic act_half;
      logic ref_edge;
      logic [scl_pkg::LOCK_W-1:0] lock_cnt;
      logic lock;
      logic [scl_pkg::DVAL_W-1:0] tmo_cnt;
      logic tmo_act;
      logic resync;
      logic dither;
      logic lnb;
      logic mux_pin;
      logic cmp_clk;
      logic cp_hiz;
      logic cnt_hold;
      logic buf_en;
      logic fast;
      logic lock_pin;
   } scl_top_state_type;

   scl_top_state_type s_q;
   scl_top_state_type s_d;
   scl_ref_if rif ();
   logic ser_rise;
   logic load_rise;
   logic w0_write;
   logic sleep;
   logic win;
   logic [scl_pkg::LOCK_W-1:0] thr;

   scl_refdiv u_refdiv (
      .ref_clk(ref_clk),
      .rst(rst),
      .rif(rif)
   );

   assign rif.ref_edge = s_q.ref_edge;
   assign rif.ratio = s_q.act_ratio;
   assign rif.halve = s_q.act_half;
   assign rif.hold = s_q.w2[scl_pkg::CRST_BIT] | s_q.w2[scl_pkg::SLEEP_BIT];

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.resync = 1'b0;
      // Second stage of each synchroniser feeds logic; clock, load and reference also use their third stage for edges
      s_d.clk_sy = {s_q.clk_sy[1:0], ser_clk};
      s_d.dat_sy = {s_q.dat_sy[0], ser_data};
      s_d.ld_sy = {s_q.ld_sy[1:0], ser_load};
      s_d.ref_sy = {s_q.ref_sy[1:0], reference_input};
      s_d.w10_sy = {s_q.w10_sy[0], win_10ns_ok};
      s_d.w6_sy = {s_q.w6_sy[0], win_6ns_ok};
      ser_rise = s_q.clk_sy[1] & ~s_q.clk_sy[2];
      load_rise = s_q.ld_sy[1] & ~s_q.ld_sy[2];
      sleep = s_q.w2[scl_pkg::SLEEP_BIT];
      w0_write = 1'b0;

      // Serial word capture; writes are taken even in sleep
      if (ser_rise) begin
         s_d.shift = {s_q.shift[30:0], s_q.dat_sy[1]};
      end
      if (load_rise) begin
         unique case (s_q.shift[scl_pkg::SEL_HI:scl_pkg::SEL_LO])
            scl_pkg::SEL_W0: begin
               w0_write = 1'b1;
            end
            scl_pkg::SEL_W2: begin
               s_d.w2 = s_q.shift;
            end
            scl_pkg::SEL_W3: begin
               s_d.w3 = s_q.shift;
            end
            scl_pkg::SEL_W5: begin
               s_d.w5 = s_q.shift;
            end
            // Words one and four carry nothing this block acts on
            default: begin
            end
         endcase
      end

      // Buffered reference setup moves over on the word-zero write
      if (w0_write) begin
         s_d.act_ratio = s_q.w2[scl_pkg::RCNT_HI:scl_pkg::RCNT_LO];
         s_d.act_dbl = s_q.w2[scl_pkg::DBL_BIT];
         s_d.act_half = s_q.w2[scl_pkg::HALF_BIT];
      end

      // Active reference edges
      if (s_q.act_dbl) begin
         s_d.ref_edge = s_q.ref_sy[1] ^ s_q.ref_sy[2];
      end else begin
         s_d.ref_edge = ~s_q.ref_sy[1] & s_q.ref_sy[2];
      end

      // Lock detection, counted in comparison cycles
      win = s_q.w2[scl_pkg::LDP_BIT] ? s_q.w6_sy[1] : s_q.w10_sy[1];
      thr = s_q.w2[scl_pkg::LDF_BIT] ? scl_pkg::LOCK_INT_CNT
                                     : scl_pkg::LOCK_FRAC_CNT;
      if (sleep) begin
         s_d.lock_cnt = '0;
         s_d.lock = 1'b0;
      end else if (rif.cmp_tick) begin
         if (!win) begin
            s_d.lock_cnt = '0;
            s_d.lock = 1'b0;
         end else if (s_q.lock_cnt < thr) begin
            s_d.lock_cnt = s_q.lock_cnt + scl_pkg::LOCK_ONE;
            s_d.lock = (s_q.lock_cnt + scl_pkg::LOCK_ONE) >= thr;
         end else begin
            s_d.lock = 1'b1;
         end
      end

      // Timeout for fast lock or phase resync, started by word zero
      if (sleep) begin
         s_d.tmo_act = 1'b0;
      end else if (w0_write) begin
         s_d.tmo_cnt = s_q.w3[scl_pkg::DVAL_HI:scl_pkg::DVAL_LO];
         s_d.tmo_act = s_q.w3[scl_pkg::DMODE_HI:scl_pkg::DMODE_LO] != 2'h0;
      end else if (s_q.tmo_act && rif.cmp_tick) begin
         if (s_q.tmo_cnt <= scl_pkg::DVAL_ONE) begin
            s_d.tmo_act = 1'b0;
            s_d.resync = s_q.w3[scl_pkg::DMODE_HI:scl_pkg::DMODE_LO]
                         == scl_pkg::DMODE_RESYNC;
         end else begin
            s_d.tmo_cnt = s_q.tmo_cnt - scl_pkg::DVAL_ONE;
         end
      end
      s_d.fast = s_q.tmo_act && s_q.w3[scl_pkg::DMODE_HI:scl_pkg::DMODE_LO]
                 == scl_pkg::DMODE_FAST;

      // Registered outputs
      s_d.dither = s_q.w2[scl_pkg::NOISE_HI:scl_pkg::NOISE_LO]
                   == scl_pkg::NOISE_LOW_SPUR;
      s_d.lnb = s_q.w2[scl_pkg::NOISE_HI:scl_pkg::NOISE_LO]
                == scl_pkg::NOISE_LOW_NOISE;
      s_d.cmp_clk = rif.cmp_tick;
      s_d.cp_hiz = s_q.w2[scl_pkg::TRI_BIT] | sleep;
      s_d.cnt_hold = s_q.w2[scl_pkg::CRST_BIT] | sleep;
      s_d.buf_en = ~sleep;
      case (s_q.w2[scl_pkg::MUX_HI:scl_pkg::MUX_LO])
         scl_pkg::MUX_HIGH: s_d.mux_pin = 1'b1;
         scl_pkg::MUX_REFDIV: s_d.mux_pin = s_q.cmp_clk;
         scl_pkg::MUX_LOCK: s_d.mux_pin = s_q.lock;
         default: s_d.mux_pin = 1'b0;
      endcase
      case (s_q.w5[scl_pkg::LPIN_HI:scl_pkg::LPIN_LO])
         scl_pkg::LPIN_LOCK: s_d.lock_pin = s_q.lock;
         scl_pkg::LPIN_HIGH: s_d.lock_pin = 1'b1;
         default: s_d.lock_pin = 1'b0;
      endcase
   end

   // ==========================================================
   // State register; words keep their contents through sleep
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   assign dither_enable = s_q.dither;
   assign cp_low_noise_bias = s_q.lnb;
   assign mux_source_sel = s_q.w2[scl_pkg::MUX_HI:scl_pkg::MUX_LO];
   assign multiplexed_output_pin = s_q.mux_pin;
   assign comparison_clk = s_q.cmp_clk;
   assign pd_polarity_pos = s_q.w2[scl_pkg::POL_BIT];
   assign charge_pump_high_z = s_q.cp_hiz;
   assign counters_hold = s_q.cnt_hold;
   assign output_buffer_en = s_q.buf_en;
   assign sleep_active = s_q.w2[scl_pkg::SLEEP_BIT];
   assign antibacklash_short = s_q.w3[scl_pkg::ABP_BIT];
   assign charge_cancel_en = s_q.w3[scl_pkg::CANCEL_BIT];
   assign slip_reduction_enable = s_q.w3[scl_pkg::CSR_BIT];
   assign divider_mode = s_q.w3[scl_pkg::DMODE_HI:scl_pkg::DMODE_LO];
   assign divider_value = s_q.w3[scl_pkg::DVAL_HI:scl_pkg::DVAL_LO];
   assign fast_lock_active = s_q.fast;
   assign resync_pulse = s_q.resync;
   assign lock_detect = s_q.lock;
   assign lock_detect_pin = s_q.lock_pin;

   // ==========================================================
   // Checks
   a_sleep_safe: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.w2[scl_pkg::SLEEP_BIT] |=>
         charge_pump_high_z && !output_buffer_en && !lock_detect)
      else $error("sleep left pump, buffers or lock active");

   a_tristate_pump: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.w2[scl_pkg::TRI_BIT] |=> charge_pump_high_z)
      else $error("pump driven while three-state bit set");

   a_frac_lock_count: assert property (
      @(posedge ref_clk) disable iff (rst)
      $rose(lock_detect) && !$past(s_q.w2[scl_pkg::LDF_BIT]) |->
         s_q.lock_cnt == scl_pkg::LOCK_FRAC_CNT)
      else $error("fractional lock without 40 good cycles");

   a_int_lock_count: assert property (
      @(posedge ref_clk) disable iff (rst)
      $rose(lock_detect) && $past(s_q.w2[scl_pkg::LDF_BIT]) |->
         s_q.lock_cnt >= scl_pkg::LOCK_INT_CNT)
      else $error("integer lock without five good cycles");

   a_word3_route: assert property (
      @(posedge ref_clk) disable iff (rst)
      load_rise && s_q.shift[scl_pkg::SEL_HI:scl_pkg::SEL_LO]
         == scl_pkg::SEL_W3 |=> s_q.w3 == $past(s_q.shift))
      else $error("third word not taken from shift register");

   a_buffer_hold: assert property (
      @(posedge ref_clk) disable iff (rst)
      !w0_write |=> $stable(s_q.act_ratio) && $stable(s_q.act_half))
      else $error("buffered field moved without word-zero write");

   a_single_edge: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.ref_edge && !$past(s_q.act_dbl) |->
         $past(s_q.ref_sy[2]) && !$past(s_q.ref_sy[1]))
      else $error("non-falling reference edge with doubler off");

   a_noise_spur: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.w2[scl_pkg::NOISE_HI:scl_pkg::NOISE_LO] == scl_pkg::NOISE_LOW_SPUR
         |=> dither_enable && !cp_low_noise_bias)
      else $error("low spur mode without dither");

   a_lock_pin_high: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.w5[scl_pkg::LPIN_HI:scl_pkg::LPIN_LO] == scl_pkg::LPIN_HIGH
         |=> lock_detect_pin)
      else $error("lock pin not high in forced-high mode");

   a_resync_single: assert property (
      @(posedge ref_clk) disable iff (rst)
      resync_pulse |=> !resync_pulse)
      else $error("phase resync pulse longer than one cycle");

   a_window_drop: assert property (
      @(posedge ref_clk) disable iff (rst)
      rif.cmp_tick && !win |=> !lock_detect && s_q.lock_cnt == '0)
      else $error("lock kept after a comparison outside the window");

   a_count_hold: assert property (
      @(posedge ref_clk) disable iff (rst)
      s_q.w2[scl_pkg::CRST_BIT] |=> counters_hold)
      else $error("counters not held while counter-reset bit set");
endmodule

// ===== rtl/scl_pkg.sv
// Purpose: Constants for the synthesizer configuration and lock-detect block
// Assumes: 32-bit serial words, control field in bits 2:0
// Notes:   Field positions index the shifted word, bit 31 arrives first
//
// Summary of operation
// - Two noise bits pick low spur (dither on) or low noise (pump bias).
// - Three bits of the second word pick the multiplexed output source.
// - Doubler off uses falling reference edges only; on uses both edges.
// - Halver bit inserts a toggle stage giving a half-rate 50% clock.
// - Ten-bit reference counter divides by any ratio from 1 to 1023.
// - Lock-function bit 1 picks integer lock detect, 0 picks fractional.
// - Fractional lock needs 40 in-window comparison cycles in a row.
// - Integer lock needs five in-window cycles; precision picks 10/6 ns.
// - One bit sets phase detector polarity for the loop filter type.
// - Sleep bit 1 powers down, 0 resumes; all words are kept.
// - Sleep loads counters, floats pump, clears lock, kills buffers.
// - Three-state bit 1 floats the charge pump output.
// - Counter-reset bit holds reference and feedback counters in reset.
// - Control field 011, 100, 101 routes to third, fourth, fifth word.
// - Antibacklash bit 0 gives 6 ns pulse, 1 gives 3 ns pulse.
// - Cancellation bit enables pump charge cancellation for integer use.
// - Slip bit enables cycle-slip reduction; controller sets 50% clock.
// - Divider mode 10 resync, 01 fast lock, 00 off; value sets timeout.
// - Two bits of the fifth word set the lock-detect pin behaviour.
// - Control field 000, 001, 010 routes to word zero, one, two.
// - Double-buffered fields take effect only on the next word-zero write.

package scl_pkg;
   // ==========================================================
   // Word framing
   localparam int WORD_W = 32;
   localparam int SEL_HI = 2;
   localparam int SEL_LO = 0;
   localparam logic [2:0] SEL_W0 = 3'h0;
   localparam logic [2:0] SEL_W2 = 3'h2;
   localparam logic [2:0] SEL_W3 = 3'h3;
   localparam logic [2:0] SEL_W5 = 3'h5;
   localparam logic [WORD_W-1:0] WORD_RESET = 32'h0;
   // ==========================================================
   // Second word fields
   localparam int NOISE_HI = 30;
   localparam int NOISE_LO = 29;
   localparam int MUX_HI = 28;
   localparam int MUX_LO = 26;
   localparam int DBL_BIT = 25;
   localparam int HALF_BIT = 24;
   localparam int RCNT_HI = 23;
   localparam int RCNT_LO = 14;
   localparam int LDF_BIT = 8;
   localparam int LDP_BIT = 7;
   localparam int POL_BIT = 6;
   localparam int SLEEP_BIT = 5;
   localparam int TRI_BIT = 4;
   localparam int CRST_BIT = 3;
   // ==========================================================
   // Third and fifth word fields
   localparam int ABP_BIT = 22;
   localparam int CANCEL_BIT = 21;
   localparam int CSR_BIT = 18;
   localparam int DMODE_HI = 16;
   localparam int DMODE_LO = 15;
   localparam int DVAL_HI = 14;
   localparam int DVAL_LO = 3;
   localparam int LPIN_HI = 23;
   localparam int LPIN_LO = 22;
   // ==========================================================
   // Encodings
   localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
   localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;
   localparam logic [1:0] DMODE_FAST = 2'h1;
   localparam logic [1:0] DMODE_RESYNC = 2'h2;
   localparam logic [1:0] LPIN_LOCK = 2'h1;
   localparam logic [1:0] LPIN_HIGH = 2'h3;
   localparam logic [2:0] MUX_HIGH = 3'h1;
   localparam logic [2:0] MUX_REFDIV = 3'h2;
   localparam logic [2:0] MUX_LOCK = 3'h3;
   // ==========================================================
   // Counters
   localparam int RCNT_W = 10;
   localparam int DVAL_W = 12;
   localparam int LOCK_W = 6;
   localparam logic [RCNT_W-1:0] RCNT_ONE = 10'h001;
   localparam logic [LOCK_W-1:0] LOCK_FRAC_CNT = 6'h28;
   localparam logic [LOCK_W-1:0] LOCK_INT_CNT = 6'h05;
   localparam logic [LOCK_W-1:0] LOCK_ONE = 6'h01;
   localparam logic [DVAL_W-1:0] DVAL_ONE = 12'h001;
endpackage

// ===== rtl/scl_ref_if.sv
// Purpose: Carrier between the control logic and the reference divider
// Assumes: Both ends on ref_clk
// Notes:   ref_edge and cmp_tick are one-cycle strobes; ratio, hold and halve are levels
`timescale 1ns/1ps
interface scl_ref_if;
   logic ref_edge;
   logic [scl_pkg::RCNT_W-1:0] ratio;
   logic hold;
   logic halve;
   logic cmp_tick;
   modport ctl(output ref_edge, ratio, hold, halve, input cmp_tick);
   modport div(input ref_edge, ratio, hold, halve, output cmp_tick);
endinterface

// ===== rtl/scl_refdiv.sv
// Purpose: Reference counter and divide-by-two toggle stage
// Assumes: ref_edge is a one-cycle strobe per active reference edge
// Notes:   Ratio 0 behaves as 1, so with halve off every edge gives a comparison tick
`timescale 1ns/1ps
module scl_refdiv (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Control side
   scl_ref_if.div rif
);
   typedef struct packed {
      logic [scl_pkg::RCNT_W-1:0] cnt;
      logic tog;
      logic tick;
   } scl_div_state_type;

   scl_div_state_type s_q;
   scl_div_state_type s_d;
   logic [scl_pkg::RCNT_W-1:0] last;

   // ==========================================================
   // Divider
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      last = (rif.ratio < scl_pkg::RCNT_ONE) ? '0
                                              : rif.ratio - scl_pkg::RCNT_ONE;
      if (rif.hold) begin
         s_d.cnt = '0;
         s_d.tog = 1'b0;
      end else if (rif.ref_edge) begin
         if (s_q.cnt >= last) begin
            s_d.cnt = '0;
            if (rif.halve) begin
               s_d.tog = ~s_q.tog;
               s_d.tick = ~s_q.tog;
            end else begin
               s_d.tick = 1'b1;
            end
         end else begin
            s_d.cnt = s_q.cnt + scl_pkg::RCNT_ONE;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rif.cmp_tick = s_q.tick;

   a_hold_no_tick: assert property (
      @(posedge ref_clk) disable iff (rst)
      rif.hold |=> !rif.cmp_tick && s_q.cnt == '0)
      else $error("comparison tick while counters held");
endmodule

// ===== sim/scl_host.sv
// Purpose: Host model that writes configuration words over the serial link
// Assumes: 800 ns link clock, phase unrelated to ref_clk
// Notes:   Link clock rests low between frames
`timescale 1ns/1ps
module scl_host (
   // Serial link
   output logic ser_clk,
   output logic ser_data,
   output logic ser_load
);
   // ==========================================================
   // Frame writer
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_load = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      #37;
      for (int i = 31; i >= 0; i--) begin
         ser_data = w[i];
         #400 ser_clk = 1'b1;
         #400 ser_clk = 1'b0;
      end
      // Undriven data line shows the inverse, never a held value
      ser_data = ~w[0];
      #400 ser_load = 1'b1;
      #400 ser_load = 1'b0;
      // Margin so the stored outputs have settled when the writer returns
      #400;
   endtask
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for the synthesizer configuration block
// Assumes: Reference input period of six ref_clk cycles
// Notes:   Driver queues expectations; a monitor process checks them
`timescale 1ns/1ps
module tb;
   typedef struct {
      int kind;
      string name;
      logic [29:0] exp;
   } scl_note_type;
   // ==========================================================
   // Signals
   logic ref_clk, rst, ser_clk, ser_data, ser_load;
   logic reference_input, win_10ns_ok, win_6ns_ok;
   logic dither_enable, cp_low_noise_bias, multiplexed_output_pin;
   logic comparison_clk, pd_polarity_pos, charge_pump_high_z;
   logic counters_hold, output_buffer_en, sleep_active, antibacklash_short;
   logic charge_cancel_en, slip_reduction_enable, fast_lock_active;
   logic resync_pulse, lock_detect, lock_detect_pin, lk, busy;
   logic [2:0] mux_source_sel;
   logic [1:0] divider_mode;
   logic [11:0] divider_value;
   logic [31:0] w2, w3, w5, rnd;
   int failures, n_tests, ph, cur, rr;
   scl_note_type notes[$];
   scl_top dut (.ref_clk, .rst, .ser_clk, .ser_data, .ser_load,
      .reference_input, .win_10ns_ok, .win_6ns_ok, .dither_enable,
      .cp_low_noise_bias, .mux_source_sel, .multiplexed_output_pin,
      .comparison_clk, .pd_polarity_pos, .charge_pump_high_z,
      .counters_hold, .output_buffer_en, .sleep_active,
      .antibacklash_short, .charge_cancel_en, .slip_reduction_enable,
      .divider_mode, .divider_value, .fast_lock_active, .resync_pulse,
      .lock_detect, .lock_detect_pin);
   scl_host host (.ser_clk, .ser_data, .ser_load);
   // ==========================================================
   // Clock and reference
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (ph == 2) reference_input <= ~reference_input;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [29:0] snap();
      return {dither_enable, cp_low_noise_bias, mux_source_sel,
         multiplexed_output_pin, pd_polarity_pos, charge_pump_high_z,
         counters_hold, output_buffer_en, sleep_active, antibacklash_short,
         charge_cancel_en, slip_reduction_enable, divider_mode,
         divider_value, lock_detect_pin, lock_detect};
   endfunction
   function automatic logic [29:0] model();
      logic [1:0] nz;
      logic [2:0] mx;
      logic [1:0] lp;
      nz = w2[30:29];
      mx = w2[28:26];
      lp = w5[23:22];
      return {nz == scl_pkg::NOISE_LOW_SPUR, nz == scl_pkg::NOISE_LOW_NOISE,
         mx, mx == scl_pkg::MUX_HIGH || (mx == scl_pkg::MUX_LOCK && lk),
         w2[6], w2[4] | w2[5], w2[3] | w2[5], ~w2[5], w2[5], w3[22],
         w3[21], w3[18], w3[16:15], w3[14:3],
         lp == scl_pkg::LPIN_HIGH || (lp == scl_pkg::LPIN_LOCK && lk), lk};
   endfunction
   task automatic note(input int k, input string s, input logic [29:0] e);
      scl_note_type n;
      n.kind = k;
      n.name = s;
      n.exp = e;
      notes.push_back(n);
      #1;
      wait (notes.size() == 0 && busy == 1'b0);
   endtask
   task automatic put(input logic [31:0] w);
      host.send(w);
      case (w[2:0])
         3'h2: w2 = w;
         3'h3: w3 = w;
         3'h5: w5 = w;
         default: ;
      endcase
   endtask
   task automatic tick();
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         #1;
         i++;
      end while (comparison_clk !== 1'b1 && i < 400);
      if (i == 400) failures++;
   endtask
   task automatic conclude();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Monitor: measures what each note asks for, then compares
   initial begin
      scl_note_type n;
      logic [29:0] seen;
      int p, t0, i;
      logic pf;
      logic pl;
      busy = 1'b0;
      forever begin
         wait (notes.size() > 0);
         while (notes.size() > 0) begin
            busy = 1'b1;
            n = notes.pop_front();
            seen = snap();
            p = 0;
            t0 = 0;
            pf = 1'b0;
            for (i = 0; i < 1000 && n.kind != 0; i++) begin
               @(posedge ref_clk);
               #1;
               pl = (n.kind == 5) ? multiplexed_output_pin : comparison_clk;
               if (pl === 1'b1 &&
                   (n.kind != 3 || fast_lock_active === 1'b1 || pf)) begin
                  p++;
                  if (p == 2) t0 = i;
               end
               if (((n.kind == 1 || n.kind == 5) && p == 3) ||
                   (n.kind == 2 && lock_detect === 1'b1) ||
                   (n.kind == 4 && resync_pulse === 1'b1) ||
                   (n.kind == 3 && pf && fast_lock_active !== 1'b1)) break;
               pf = (fast_lock_active === 1'b1);
            end
            if (n.kind == 1 || n.kind == 5) begin
               seen = (p == 3) ? 30'(i - t0) : 30'h0;
            end else if (n.kind > 1) begin
               seen = 30'(p);
            end
            n_tests++;
            if (seen !== n.exp) begin
               failures++;
               $display("mismatch %s expected %h seen %h", n.name, n.exp,
                  seen);
            end
            busy = 1'b0;
         end
      end
   end
   // Hang guard, far above the expected run length
   initial begin
      #5000000;
      failures++;
      conclude();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      reference_input = 1'b0;
      win_10ns_ok = 1'b0;
      win_6ns_ok = 1'b0;
      w2 = 32'h0;
      w3 = 32'h0;
      w5 = 32'h0;
      lk = 1'b0;
      rnd = 32'hB2F8;
      cur = 6;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      note(0, "reset", model());
      put(32'h00000005);
      put(32'h00800004);
      put(32'h00000003);
      put(32'h00000182);
      put(32'h00000001);
      put(32'h00000000);
      note(0, "init", model());
      for (int k = 0; k < 12; k++) begin
         rnd = xs(rnd);
         case (k % 4)
            0: put({rnd[31:29], (rnd[28:26] == 3'h2) ? 3'h1 : rnd[28:26],
                  rnd[25:3], 3'h2});
            1: put({rnd[31:19], 1'b0, rnd[17:3], 3'h3});
            2: put({rnd[31:3], 3'h5});
            default: put({rnd[31:3], 3'h1});
         endcase
         note(0, "cfg", model());
      end
      put(32'h00000003);
      for (int k = 0; k < 4; k++) begin
         rnd = xs(rnd);
         rr = (k == 0) ? 1 : 2 + int'(rnd[1:0]);
         put({3'h0, scl_pkg::MUX_REFDIV, k[0], k[1], 10'(rr), 11'h008,
            3'h2});
         note(1, "old rate", 30'(cur));
         put(32'h00000000);
         cur = rr * (k[0] ? 3 : 6) * (k[1] ? 2 : 1);
         note(1, "rate", 30'(cur));
         note(5, "mux rate", 30'(cur));
      end
      put(w2 | 32'h00000008);
      note(1, "held", 30'h0);
      put(w2 & ~32'h1C000008);
      // Halver is on here, so slip reduction is allowed
      rnd = xs(rnd);
      put({13'h0, 1'b1, 1'b0, scl_pkg::DMODE_FAST, 12'(rnd[2:0]) + 12'h2,
         3'h3});
      note(0, "slip", model());
      fork
         put(32'h00000000);
         note(3, "fast lock ticks", 30'(w3[14:3]));
      join
      // Counters held so the timeout starts with no tick pending
      put(w2 | 32'h00000008);
      put({15'h0, scl_pkg::DMODE_RESYNC, 12'h003, 3'h3});
      put(32'h00000000);
      fork
         put(w2 & ~32'h00000008);
         note(4, "resync ticks", 30'h3);
      join
      put(32'h00400005);
      put(32'h0C0041C2);
      put(32'h00000000);
      tick();
      @(posedge ref_clk);
      win_6ns_ok <= 1'b1;
      note(2, "int lock", 30'h5);
      // Pins follow the lock flag one clock later
      repeat (2) @(posedge ref_clk);
      #1;
      lk = 1'b1;
      note(0, "locked", model());
      @(posedge ref_clk);
      win_6ns_ok <= 1'b0;
      tick();
      tick();
      lk = 1'b0;
      note(0, "unlocked", model());
      put(32'h0C004042);
      tick();
      @(posedge ref_clk);
      win_10ns_ok <= 1'b1;
      note(2, "frac lock", 30'h28);
      repeat (2) @(posedge ref_clk);
      #1;
      lk = 1'b1;
      note(0, "frac locked", model());
      put(w2 | 32'h00000020);
      lk = 1'b0;
      note(0, "sleep", model());
      note(1, "sleep ticks", 30'h0);
      put(32'h00600003);
      note(0, "sleep write", model());
      put(w2 & ~32'h00000020);
      note(0, "wake", model());
      conclude();
   end
endmodule
